// ===== rtl/thread_cfg_pkg.sv
// Operation
// [R01] Optional per-processor resource word, read-only
// [R02] Bit 31 media, bit 30 float capability
// [R03] Bits 27:20 count persistent instruction-state instances
// [R04] Bits 17:10 cop2, 7:0 fpu context counts
// [R05] Unused resource word bits read zero
// [R06] Control register held per virtual processor
// [R07] Yield intercept bit 21 raises scheduler exception
// [R08] Gating intercept bit 20 raises scheduler exception
// [R09] Bits 18:16 hold last thread exception subcode
// [R10] Bit 15 enable, set/cleared by instructions
// [R11] Enable clear stops thread scheduling
// [R12] After reset only context zero runs
// [R13] Clearing enable suspends all but clearing thread
// [R14] Software waits on hazard barrier after clearing
// [R15] Bits 7:0 select cross-thread move target
// [R16] Unused control bits read as zero
// [R17] Writes change only read-write control fields
package thread_cfg_pkg;
  localparam int unsigned MEDIA_BIT = 31;
  localparam int unsigned FLOAT_BIT = 30;
  localparam int unsigned INSTR_STATE_LSB = 20;
  localparam int unsigned COP2_LSB = 10;
  localparam int unsigned FPU_LSB = 0;
  localparam int unsigned YIELD_ICPT_BIT = 21;
  localparam int unsigned GATE_ICPT_BIT = 20;
  localparam int unsigned SUB_LSB = 16;
  localparam int unsigned SCHED_EN_BIT = 15;
  localparam int unsigned TARG_LSB = 0;
  localparam logic YIELD_ICPT_RESET = 1'h0;
  localparam logic GATE_ICPT_RESET = 1'h0;
  localparam logic SCHED_EN_RESET = 1'h0;
  localparam logic [7:0] TARG_RESET = 8'h00;
  localparam logic [2:0] SUB_RESET = 3'h0;
  localparam logic [7:0] RUN_CTX_RESET = 8'h00;
  localparam logic [31:0] CTRL_RW_MASK = 32'h003080FF;

  typedef enum logic [2:0] {
    EXC_UNDERFLOW = 3'h0,
    EXC_OVERFLOW = 3'h1,
    EXC_BAD_YIELD = 3'h2,
    EXC_GATING = 3'h3,
    EXC_YIELD_SCHED = 3'h4,
    EXC_GATING_SCHED = 3'h5
  } exc_sub_type;

  typedef struct packed {
    logic media;
    logic flt;
    logic [7:0] instr_state_count;
    logic [7:0] cop2_count;
    logic [7:0] fpu_count;
  } resource_cfg_type;

  typedef struct packed {
    logic wr;
    logic [31:0] data;
  } reg_write_type;

  // Thread events seen by this virtual processor
  typedef struct packed {
    logic exc_valid;
    logic [2:0] exc_code;
    logic yield_block;
    logic gating_block;
    logic trigger;
    logic enable_mt;
    logic disable_mt;
    logic [7:0] issuer;
  } thread_event_type;
endpackage

// ===== rtl/resource_cfg_word.sv
`timescale 1ns/100ps
module resource_cfg_word (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input thread_cfg_pkg::resource_cfg_type cfg_i,
  output logic [31:0] word_o
);
  logic [31:0] word;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word <= 32'h00000000;
    end else begin
      word <= 32'h00000000; // R05
      word[thread_cfg_pkg::MEDIA_BIT] <= cfg_i.media; // R02
      word[thread_cfg_pkg::FLOAT_BIT] <= cfg_i.flt;
      word[thread_cfg_pkg::INSTR_STATE_LSB +: 8] <=
          cfg_i.instr_state_count; // R03
      word[thread_cfg_pkg::COP2_LSB +: 8] <= cfg_i.cop2_count; // R04
      word[thread_cfg_pkg::FPU_LSB +: 8] <= cfg_i.fpu_count;
    end
  end
  assign word_o = word;
  AST_RESV_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (word[29:28] == 2'h0) && (word[19:18] == 2'h0) && (word[9:8] == 2'h0))
    else $error("reserved resource bits nonzero"); // R05
endmodule

// ===== rtl/sched_exc_detect.sv
`timescale 1ns/100ps
module sched_exc_detect (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic yield_icpt_i,
  input wire logic gate_icpt_i,
  input thread_cfg_pkg::thread_event_type ev_i,
  output logic exc_o,
  output logic [2:0] code_o
);
  logic y_hit;
  logic g_hit;
  assign y_hit = yield_icpt_i && ev_i.trigger && ev_i.yield_block; // R07
  assign g_hit = gate_icpt_i && ev_i.trigger && ev_i.gating_block; // R08
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exc_o <= 1'b0;
      code_o <= thread_cfg_pkg::SUB_RESET;
    end else begin
      exc_o <= ev_i.exc_valid || y_hit || g_hit;
      if (ev_i.exc_valid) begin
        code_o <= ev_i.exc_code;
      end else if (y_hit) begin
        code_o <= thread_cfg_pkg::EXC_YIELD_SCHED;
      end else begin
        code_o <= thread_cfg_pkg::EXC_GATING_SCHED;
      end
    end
  end
  AST_YIELD_EXC: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (y_hit && !ev_i.exc_valid) |=> exc_o && code_o == 3'h4)
    else $error("yield intercept missed"); // R07
  AST_GATE_EXC: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (g_hit && !y_hit && !ev_i.exc_valid) |=> exc_o && code_o == 3'h5)
    else $error("gating intercept missed"); // R08
endmodule

// ===== rtl/thread_config_control_regs.sv
`timescale 1ns/100ps
module thread_config_control_regs (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input thread_cfg_pkg::resource_cfg_type cfg_i,
  input thread_cfg_pkg::reg_write_type ctrl_wr_i,
  input thread_cfg_pkg::thread_event_type ev_i,
  output logic [31:0] resource_word_o,
  output logic [31:0] ctrl_word_o,
  output logic multi_thread_o,
  output logic [7:0] run_ctx_o,
  output logic single_thread_o,
  output logic [7:0] target_ctx_o,
  output logic exc_o
);
  logic yield_icpt;
  logic gate_icpt;
  logic sched_en;
  logic [2:0] sub;
  logic [7:0] targ;
  logic [7:0] run_ctx;
  logic det_exc;
  logic [2:0] det_code;
  logic [31:0] ctrl;

  // R01
  resource_cfg_word u_cfg (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cfg_i(cfg_i),
    .word_o(resource_word_o)
  );

  sched_exc_detect u_det (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .yield_icpt_i(yield_icpt),
    .gate_icpt_i(gate_icpt),
    .ev_i(ev_i),
    .exc_o(det_exc),
    .code_o(det_code)
  );

  // One instance per virtual processor R06
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      yield_icpt <= thread_cfg_pkg::YIELD_ICPT_RESET;
      gate_icpt <= thread_cfg_pkg::GATE_ICPT_RESET;
      targ <= thread_cfg_pkg::TARG_RESET;
    end else if (ctrl_wr_i.wr) begin
      yield_icpt <= ctrl_wr_i.data[thread_cfg_pkg::YIELD_ICPT_BIT]; // R07
      gate_icpt <= ctrl_wr_i.data[thread_cfg_pkg::GATE_ICPT_BIT]; // R08
      targ <= ctrl_wr_i.data[thread_cfg_pkg::TARG_LSB +: 8]; // R15
    end
  end

  // Instructions win over a same-cycle register write
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sched_en <= thread_cfg_pkg::SCHED_EN_RESET;
    end else if (ev_i.disable_mt) begin
      sched_en <= 1'b0; // R10
    end else if (ev_i.enable_mt) begin
      sched_en <= 1'b1;
    end else if (ctrl_wr_i.wr) begin
      sched_en <= ctrl_wr_i.data[thread_cfg_pkg::SCHED_EN_BIT];
    end
  end

  // Subcode only moves on a dispatched exception
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sub <= thread_cfg_pkg::SUB_RESET;
    end else if (det_exc) begin
      sub <= det_code; // R09 R17
    end
  end

  // Context kept running when scheduling is off
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_ctx <= thread_cfg_pkg::RUN_CTX_RESET; // R12
    end else if (ev_i.disable_mt || (ctrl_wr_i.wr && sched_en &&
        !ctrl_wr_i.data[thread_cfg_pkg::SCHED_EN_BIT])) begin
      run_ctx <= ev_i.issuer; // R13
    end
  end

  always_comb begin
    ctrl = 32'h00000000; // R16
    ctrl[thread_cfg_pkg::YIELD_ICPT_BIT] = yield_icpt;
    ctrl[thread_cfg_pkg::GATE_ICPT_BIT] = gate_icpt;
    ctrl[thread_cfg_pkg::SUB_LSB +: 3] = sub;
    ctrl[thread_cfg_pkg::SCHED_EN_BIT] = sched_en;
    ctrl[thread_cfg_pkg::TARG_LSB +: 8] = targ;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_word_o <= 32'h00000000;
      multi_thread_o <= 1'b0;
      single_thread_o <= 1'b1;
      run_ctx_o <= thread_cfg_pkg::RUN_CTX_RESET;
      target_ctx_o <= thread_cfg_pkg::TARG_RESET;
      exc_o <= 1'b0;
    end else begin
      ctrl_word_o <= ctrl;
      multi_thread_o <= sched_en; // R11
      single_thread_o <= !sched_en;
      run_ctx_o <= run_ctx;
      target_ctx_o <= targ;
      exc_o <= det_exc;
    end
  end

  AST_EN_CLEAR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ev_i.disable_mt |=> !sched_en ##1 !multi_thread_o)
    else $error("disable did not clear enable"); // R10
  AST_EN_SET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ev_i.enable_mt && !ev_i.disable_mt) |=> sched_en)
    else $error("enable did not set"); // R10
  AST_NO_SCHED: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !sched_en |=> single_thread_o && !multi_thread_o)
    else $error("scheduling while disabled"); // R11
  AST_RESV_CTRL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_word_o & ~thread_cfg_pkg::CTRL_RW_MASK & 32'hFFF8FFFF) == 0)
    else $error("reserved control bits nonzero"); // R16
  AST_SUB_HOLD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !det_exc |=> $stable(sub))
    else $error("subcode moved without exception"); // R17
  AST_TARGET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ctrl_wr_i.wr |=> ##1 target_ctx_o == $past(ctrl_wr_i.data[7:0], 2))
    else $error("target context not written"); // R15
  AST_SUSPEND: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ev_i.disable_mt |=> ##1 run_ctx_o == $past(ev_i.issuer, 2))
    else $error("wrong surviving context"); // R13
endmodule

// ===== verif/thread_config_control_regs_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module thread_config_control_regs_tb_top;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  thread_cfg_pkg::resource_cfg_type cfg_i = '0;
  thread_cfg_pkg::reg_write_type ctrl_wr_i = '0;
  thread_cfg_pkg::thread_event_type ev_i = '0;
  thread_cfg_pkg::thread_event_type e;
  logic [31:0] resource_word_o, ctrl_word_o, exp_ctrl = '0, d;
  logic [31:0] last_ctrl = '0, last_res = '0;
  logic multi_thread_o, single_thread_o, exc_o;
  logic [7:0] run_ctx_o, target_ctx_o, exp_run = '0, lfsr = 8'h3A;
  logic [39:0] note;
  logic [39:0] ctrl_q[$];
  logic [31:0] res_q[$];
  int num_errors = 0, n_checks = 0, n_exc = 0, exp_exc = 0;
  thread_config_control_regs u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .cfg_i(cfg_i), .ctrl_wr_i(ctrl_wr_i), .ev_i(ev_i),
    .resource_word_o(resource_word_o), .ctrl_word_o(ctrl_word_o),
    .multi_thread_o(multi_thread_o), .run_ctx_o(run_ctx_o),
    .single_thread_o(single_thread_o), .target_ctx_o(target_ctx_o),
    .exc_o(exc_o));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] next_rand(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Notes an expected control word only when it differs from the last one
  task automatic put(logic [31:0] v);
    if (v !== exp_ctrl) ctrl_q.push_back({exp_run, v});
    exp_ctrl = v;
  endtask
  task automatic wr(logic [31:0] v, logic [7:0] who);
    if (exp_ctrl[15] && !v[15]) exp_run = who;
    put((v & thread_cfg_pkg::CTRL_RW_MASK) |
        (exp_ctrl & ~thread_cfg_pkg::CTRL_RW_MASK));
    @(posedge mclk_i);
    ctrl_wr_i <= {1'b1, v};
    ev_i.issuer <= who;
    @(posedge mclk_i);
    ctrl_wr_i.wr <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic evt(thread_cfg_pkg::thread_event_type x, logic [31:0] v,
                     int ex);
    exp_exc += ex;
    put(v);
    @(posedge mclk_i);
    ev_i <= x;
    @(posedge mclk_i);
    ev_i <= '0;
    repeat (4) @(posedge mclk_i);
  endtask
  function automatic logic [31:0] sub(logic [2:0] c);
    return {exp_ctrl[31:19], c, exp_ctrl[15:0]};
  endfunction
  always @(negedge mclk_i) begin
    if (arst_n_i) begin
      if (exc_o === 1'b1) n_exc++;
      if (ctrl_word_o !== last_ctrl) begin
        last_ctrl = ctrl_word_o;
        if (ctrl_q.size() == 0) `CHK(ctrl_word_o, exp_ctrl)
        else begin
          note = ctrl_q.pop_front();
          `CHK(ctrl_word_o, note[31:0])
          `CHK(run_ctx_o, note[39:32])
          `CHK(target_ctx_o, note[7:0])
          `CHK(multi_thread_o, note[15])
          `CHK(single_thread_o, ~note[15])
        end
      end
      if (resource_word_o !== last_res) begin
        last_res = resource_word_o;
        `CHK(resource_word_o, res_q.pop_front())
      end
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(negedge mclk_i);
    `CHK(ctrl_word_o, 32'h00000000)
    `CHK({single_thread_o, run_ctx_o}, 9'h100)
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      @(posedge mclk_i);
      cfg_i <= {lfsr[0], lfsr[1], lfsr, ~lfsr, lfsr ^ 8'h5A};
      res_q.push_back({lfsr[0], lfsr[1], 2'h0, lfsr, 2'h0, ~lfsr, 2'h0,
                       lfsr ^ 8'h5A});
      repeat (4) @(posedge mclk_i);
    end
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        lfsr = next_rand(lfsr);
        d[j*8 +: 8] = lfsr;
      end
      wr(d, lfsr);
    end
    wr(32'hFFFFFFFF, 8'h00);
    wr(32'h00000000, 8'h07);
    e = '0;
    e.enable_mt = 1'b1;
    evt(e, exp_ctrl | 32'h00008000, 0);
    e = '0;
    e.disable_mt = 1'b1;
    e.issuer = 8'h21;
    exp_run = 8'h21;
    evt(e, exp_ctrl & ~32'h00008000, 0);
    for (int c = 1; c <= 6; c++) begin
      e = '0;
      e.exc_valid = 1'b1;
      e.exc_code = 3'(c % 6);
      evt(e, sub(3'(c % 6)), 1);
    end
    wr(32'h00200000, 8'h21);
    e = '0;
    e.yield_block = 1'b1;
    evt(e, exp_ctrl, 0);
    e.trigger = 1'b1;
    evt(e, sub(3'h4), 1);
    wr(32'h00100000, 8'h21);
    e = '0;
    e.gating_block = 1'b1;
    e.trigger = 1'b1;
    evt(e, sub(3'h5), 1);
    repeat (6) @(posedge mclk_i);
    `CHK(n_exc, exp_exc)
    `CHK(ctrl_q.size(), 0)
    end_of_test();
  end
endmodule
